// ==== inc/flash_host_pkg.sv ====
// Constants, carriers and state layout for the parallel flash host controller
// Notes on behaviour
// - Resume is data 30 at any address; honoured only while suspended.
// - Program, erase and identification commands start with AA at 555 then 55 at 2AA.
// - Third write picks program A0, or erase 80 then chip 10 or sector 30.
// - F0 at any address returns to array reading; exits identification or failure.
// - Identification is unlock pair plus 90 at 555, then a read.
// - After top bit turns true, read the full byte again on a later cycle.
// - When failure bit is 1, re-read the polling bit before declaring failure.
package flash_host_pkg;

  // Flash geometry
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;

  // Command bytes and unlock addresses
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_1 = 19'h0_0555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_2 = 19'h0_02aa;
  localparam logic [7:0] CMD_UNLOCK_1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK_2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_IDENT = 8'h90;

  // Status bit positions on the data lines
  localparam int POLL_BIT = 7;
  localparam int FAIL_BIT = 5;

  // Bus timing at the clock rate
  localparam int CLK_MHZ = 200;
  localparam int T_ACC_NS = 70;
  localparam int T_WP_NS = 35;
  localparam int T_REC_NS = 30;
  localparam int SYNC_STAGES = 2;
  localparam int RD_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES;
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int REC_CYC = (T_REC_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 5;

  // Software register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int CTRL_POLL_BIT = 8;

  // Operations that software may start
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_RESET = 4'h1,
    OP_PROGRAM = 4'h2,
    OP_CHIP_ERASE = 4'h3,
    OP_SECTOR_ERASE = 4'h4,
    OP_SECTOR_ADD = 4'h5,
    OP_SUSPEND = 4'h6,
    OP_RESUME = 4'h7,
    OP_IDENT = 4'h8,
    OP_POLL = 4'h9
  } op_t;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_SETUP = 3'b001,
    PH_STROBE = 3'b010,
    PH_HOLD = 3'b011,
    PH_RECOVER = 3'b100
  } phase_t;

  // APB carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // Flash pin outputs
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } flash_pins_t;

  // One bus cycle of a command sequence
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic last;
  } bus_cycle_t;

  // Whole controller state
  typedef struct packed {
    phase_t phase;
    op_t op;
    logic [2:0] step;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic poll_en;
    logic in_poll;
    logic [1:0] poll_stage;
    logic fin;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] rd_data;
    logic busy;
    logic done;
    logic fail;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
    flash_pins_t pins;
    apb_rsp_t rsp;
  } state_t;

  localparam flash_pins_t PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                         addr: '0, dq_out: '0, dq_oe: 1'b0};

endpackage : flash_host_pkg

// ==== core/flash_host.sv ====
// Host controller that drives a parallel flash through its command sequences
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

module flash_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire flash_host_pkg::apb_req_t apb_req,
  output var flash_host_pkg::apb_rsp_t apb_rsp,
  // Flash pins
  output var flash_host_pkg::flash_pins_t flash_pins,
  input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in
);
  import flash_host_pkg::*;

  localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);
  localparam logic [CNT_W-1:0] WP_CNT = CNT_W'(WP_CYC);
  localparam logic [CNT_W-1:0] REC_CNT = CNT_W'(REC_CYC);

  state_t s_r;
  state_t s_nxt;

  // Write cycle helper
  function automatic bus_cycle_t wcyc(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                                      input logic last);
    wcyc = '{wr: 1'b1, addr: a, data: d, last: last};
  endfunction : wcyc

  // Bus cycle at a given step of an operation's command sequence
  function automatic bus_cycle_t seq_step(input op_t op, input logic [2:0] step,
                                          input logic [ADDR_W-1:0] a,
                                          input logic [7:0] d);
    bus_cycle_t c;
    c = '{wr: 1'b0, addr: a, data: '0, last: 1'b1};
    unique case (op)
      OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_IDENT: begin
        unique case (step)
          3'd0: c = wcyc(UNLOCK_ADDR_1, CMD_UNLOCK_1, 1'b0);
          3'd1: c = wcyc(UNLOCK_ADDR_2, CMD_UNLOCK_2, 1'b0);
          3'd2: begin
            if (op == OP_PROGRAM) begin
              c = wcyc(UNLOCK_ADDR_1, CMD_PROGRAM, 1'b0);
            end else if (op == OP_IDENT) begin
              c = wcyc(UNLOCK_ADDR_1, CMD_IDENT, 1'b0);
            end else begin
              c = wcyc(UNLOCK_ADDR_1, CMD_ERASE_SETUP, 1'b0);
            end
          end
          3'd3: begin
            if (op == OP_PROGRAM) begin
              c = wcyc(a, d, 1'b1);
            end else if (op == OP_IDENT) begin
              c = '{wr: 1'b0, addr: a, data: '0, last: 1'b1};
            end else begin
              c = wcyc(UNLOCK_ADDR_1, CMD_UNLOCK_1, 1'b0);
            end
          end
          3'd4: c = wcyc(UNLOCK_ADDR_2, CMD_UNLOCK_2, 1'b0);
          default: begin
            if (op == OP_CHIP_ERASE) begin
              c = wcyc(UNLOCK_ADDR_1, CMD_CHIP_ERASE, 1'b1);
            end else begin
              c = wcyc(a, CMD_SECTOR_ERASE, 1'b1);
            end
          end
        endcase
      end
      OP_RESET: c = wcyc(a, CMD_RESET, 1'b1);
      OP_SUSPEND: c = wcyc(a, CMD_SUSPEND, 1'b1);
      OP_RESUME: c = wcyc(a, CMD_RESUME, 1'b1);
      OP_SECTOR_ADD: c = wcyc(a, CMD_SECTOR_ERASE, 1'b1);
      default: c = '{wr: 1'b0, addr: a, data: '0, last: 1'b1};
    endcase
    seq_step = c;
  endfunction : seq_step

  bus_cycle_t cyc;
  logic target_bit;
  logic [DATA_W-1:0] rd;
  logic acc_phase;
  logic wr_done;

  // Sequencer, read polling and APB slave in one next-state process
  always_comb begin
    s_nxt = s_r;
    rd = s_r.sync2;
    // Program polls for the true datum bit, erase polls for a one
    target_bit = (s_r.op == OP_PROGRAM) ? s_r.wdata[POLL_BIT] : 1'b1;
    if (s_r.in_poll) begin
      cyc = '{wr: 1'b0, addr: s_r.addr, data: '0, last: 1'b0};
    end else begin
      cyc = seq_step(s_r.op, s_r.step, s_r.addr, s_r.wdata);
    end

    // Two-stage input synchroniser
    s_nxt.sync1 = flash_dq_in;
    s_nxt.sync2 = s_r.sync1;

    unique case (s_r.phase)
      PH_IDLE: begin
        s_nxt.pins = PINS_IDLE;
      end
      PH_SETUP: begin
        // Chip enable and address lead the strobe so the address latches on it
        s_nxt.pins.addr = cyc.addr;
        s_nxt.pins.dq_out = cyc.data;
        s_nxt.pins.dq_oe = cyc.wr;
        s_nxt.pins.ce_n = 1'b0;
        s_nxt.cnt = cyc.wr ? WP_CNT : RD_CNT;
        s_nxt.phase = PH_STROBE;
      end
      PH_STROBE: begin
        s_nxt.pins.we_n = ~cyc.wr;
        s_nxt.pins.oe_n = cyc.wr;
        s_nxt.cnt = s_r.cnt - CNT_W'(1);
        if (s_r.cnt == '0) begin
          // Strobe rises first while data still driven and chip enabled
          s_nxt.pins.we_n = 1'b1;
          s_nxt.pins.oe_n = 1'b1;
          s_nxt.phase = PH_HOLD;
          if (s_r.in_poll) begin
            unique case (s_r.poll_stage)
              2'd0: begin
                if (rd[POLL_BIT] == target_bit) begin
                  s_nxt.poll_stage = 2'd1;
                end else if (rd[FAIL_BIT]) begin
                  s_nxt.poll_stage = 2'd2;
                end
              end
              2'd1: begin
                s_nxt.rd_data = rd;
                s_nxt.fin = 1'b1;
              end
              default: begin
                if (rd[POLL_BIT] == target_bit) begin
                  s_nxt.poll_stage = 2'd1;
                end else begin
                  s_nxt.rd_data = rd;
                  s_nxt.fail = 1'b1;
                  s_nxt.fin = 1'b1;
                end
              end
            endcase
          end else if (!cyc.last) begin
            s_nxt.step = s_r.step + 3'd1;
          end else if (!cyc.wr) begin
            s_nxt.rd_data = rd;
            s_nxt.fin = 1'b1;
          end else if (s_r.poll_en) begin
            s_nxt.in_poll = 1'b1;
          end else begin
            s_nxt.fin = 1'b1;
          end
        end
      end
      PH_HOLD: begin
        s_nxt.pins.ce_n = 1'b1;
        s_nxt.pins.dq_oe = 1'b0;
        s_nxt.cnt = REC_CNT;
        s_nxt.phase = PH_RECOVER;
      end
      default: begin
        s_nxt.cnt = s_r.cnt - CNT_W'(1);
        if (s_r.cnt == '0) begin
          if (s_r.fin) begin
            s_nxt.phase = PH_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.phase = PH_SETUP;
          end
        end
      end
    endcase

    // APB access phase answers one cycle after it opens
    acc_phase = apb_req.psel && apb_req.penable;
    wr_done = acc_phase && s_r.rsp.pready && apb_req.pwrite;
    s_nxt.rsp.pready = acc_phase && !s_r.rsp.pready;
    s_nxt.rsp.pslverr = 1'b0;
    if (acc_phase && !s_r.rsp.pready) begin
      s_nxt.rsp.prdata = '0;
      unique case (apb_req.paddr)
        REG_CTRL: s_nxt.rsp.prdata = {23'h00_0000, s_r.poll_en, 4'h0, s_r.op};
        REG_ADDR: s_nxt.rsp.prdata = {13'h0000, s_r.addr};
        REG_WDATA: s_nxt.rsp.prdata = {24'h00_0000, s_r.wdata};
        REG_STATUS: s_nxt.rsp.prdata = {29'h0000_0000, s_r.fail, s_r.done, s_r.busy};
        REG_RDATA: s_nxt.rsp.prdata = {24'h00_0000, s_r.rd_data};
        default: s_nxt.rsp.pslverr = 1'b1;
      endcase
    end

    // Register writes take effect at the completing edge; writes while busy are dropped
    if (wr_done && !s_r.busy) begin
      unique case (apb_req.paddr)
        REG_ADDR: s_nxt.addr = apb_req.pwdata[ADDR_W-1:0];
        REG_WDATA: s_nxt.wdata = apb_req.pwdata[DATA_W-1:0];
        REG_CTRL: begin
          s_nxt.op = op_t'(apb_req.pwdata[3:0]);
          s_nxt.poll_en = apb_req.pwdata[CTRL_POLL_BIT];
          s_nxt.step = '0;
          s_nxt.in_poll = (op_t'(apb_req.pwdata[3:0]) == OP_POLL);
          s_nxt.poll_stage = '0;
          s_nxt.fin = 1'b0;
          s_nxt.busy = 1'b1;
          s_nxt.done = 1'b0;
          s_nxt.fail = 1'b0;
          s_nxt.phase = PH_SETUP;
        end
        default: begin
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{phase: PH_IDLE, op: OP_READ, pins: PINS_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign apb_rsp = s_r.rsp;
  assign flash_pins = s_r.pins;

endmodule : flash_host

`default_nettype wire

// ==== tb/flash_host_asserts.sv ====
// Checker for bus and flash strobe timing of the flash host controller
`timescale 1ns/100ps
`default_nettype none
module flash_host_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire flash_host_pkg::apb_req_t apb_req,
  input wire flash_host_pkg::apb_rsp_t apb_rsp,
  // Flash pins
  input wire flash_host_pkg::flash_pins_t flash_pins,
  input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in
);
  import flash_host_pkg::*;
  logic [4:0] oe_cnt_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Counts the cycles the read strobe has been low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) oe_cnt_r <= 5'h00;
    else oe_cnt_r <= flash_pins.oe_n ? 5'h00 : oe_cnt_r + 5'h01;
  end
  a_ready_late: assert property (apb_req.psel && !apb_req.penable |-> ##2 apb_rsp.pready)
    else $error("late ready");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("long ready");
  a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("lone error");
  a_we_width: assert property ($fell(flash_pins.we_n) |->
    (!flash_pins.we_n)[*7] ##1 flash_pins.we_n) else $error("write width");
  a_we_stable: assert property (!flash_pins.we_n |-> !flash_pins.ce_n && flash_pins.dq_oe
    && $stable(flash_pins.addr) && $stable(flash_pins.dq_out)) else $error("write moved");
  a_oe_width: assert property ($rose(flash_pins.oe_n) |-> oe_cnt_r == 5'h10)
    else $error("read width");
  a_read_quiet: assert property (!flash_pins.oe_n |->
    flash_pins.we_n && !flash_pins.dq_oe && !flash_pins.ce_n) else $error("read clash");
  a_recover: assert property ($rose(flash_pins.ce_n) |-> flash_pins.ce_n[*6])
    else $error("short gap");
  c_write: cover property ($fell(flash_pins.we_n));
  c_read: cover property ($rose(flash_pins.oe_n));
  c_error: cover property (apb_rsp.pslverr);
endmodule : flash_host_asserts
bind flash_host flash_host_asserts chk_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .flash_pins(flash_pins), .flash_dq_in(flash_dq_in));
`default_nettype wire

// ==== tb/flash_dev_model.sv ====
// Behavioural parallel flash device answering the host controller
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'hc3, // Arbitrary value
  parameter logic [7:0] PROT = 8'h80
) (
  // Host side
  input wire flash_host_pkg::flash_pins_t pins,
  input wire logic fail_en,
  // Data lines
  output wire logic [7:0] dq
);
  import flash_host_pkg::*;
  logic [7:0] mem [int];
  logic [18:0] a_r, program_addr_r;
  logic [7:0] program_byte_r, v, sect_r;
  logic [7:0] last_r = 8'h00;
  logic [2:0] seq_r = 3'h0;
  logic susp_r = 1'b0, id_r = 1'b0, tog_r = 1'b0, fl_r = 1'b0, chip_r = 1'b0;
  int pb_r = 0, eb_r = 0, win_r = 0;
  wire wr_n = pins.we_n | pins.ce_n;
  function automatic logic [7:0] rd(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : rd
  // Address at the later falling strobe
  always @(negedge wr_n) a_r = pins.addr;
  // Command decoder, data taken at the earlier rising strobe
  always @(posedge wr_n) begin : dec
    logic [7:0] d;
    d = pins.dq_out;
    if (pb_r > 0) begin
      if (fl_r && d == CMD_RESET) begin
        fl_r = 1'b0;
        pb_r = 0;
      end
    end else if (d == CMD_SUSPEND) begin
      if (eb_r > 0 && !chip_r) begin
        susp_r = 1'b1;
        win_r = 0;
      end
    end else if (susp_r && seq_r == 3'h0 && d == CMD_RESUME) begin
      susp_r = 1'b0;
    end else if (d == CMD_RESET) begin
      seq_r = 3'h0;
      id_r = 1'b0;
    end else if (eb_r > 0 && !susp_r) begin
      if (win_r > 0 && d == CMD_SECTOR_ERASE) begin
        sect_r[a_r[18:16]] = 1'b1;
        win_r = 500;
      end else if (win_r > 0) begin
        eb_r = 0;
        win_r = 0;
      end
    end else begin
      case (seq_r)
        3'h0, 3'h4: seq_r = (d == CMD_UNLOCK_1 && a_r[10:0] == 11'h555) ? seq_r + 3'h1 : 3'h0;
        3'h1, 3'h5: seq_r = (d == CMD_UNLOCK_2 && a_r[10:0] == 11'h2aa) ? seq_r + 3'h1 : 3'h0;
        3'h2: begin
          id_r = id_r | (d == CMD_IDENT);
          seq_r = (d == CMD_PROGRAM) ? 3'h3 : (d == CMD_ERASE_SETUP && !susp_r) ? 3'h4 : 3'h0;
        end
        3'h3: begin
          program_addr_r = a_r;
          program_byte_r = d;
          pb_r = PROT[a_r[18:16]] ? 20 : 30;
          seq_r = 3'h0;
        end
        default: begin
          chip_r = (d == CMD_CHIP_ERASE);
          sect_r = chip_r ? 8'hff : 8'h01 << a_r[18:16];
          eb_r = ((sect_r & ~PROT) == 8'h00) ? 1000 : 200;
          win_r = chip_r ? 0 : 500;
          seq_r = 3'h0;
        end
      endcase
    end
  end
  // Internal time base of 100 ns ticks
  always #100 begin
    if (pb_r > 0 && !fl_r) begin
      pb_r = pb_r - 1;
      if (pb_r == 0 && fail_en) begin
        fl_r = 1'b1;
        pb_r = 1;
      end else if (pb_r == 0 && !PROT[program_addr_r[18:16]]) begin
        mem[program_addr_r] = rd(program_addr_r) & program_byte_r;
      end
    end
    // Sector window runs out before the erase itself counts down
    if (win_r > 0 && !susp_r) win_r = win_r - 1;
    else if (eb_r > 0 && !susp_r) eb_r = eb_r - 1;
  end
  // Byte presented while selected for reading
  always @* begin
    if (pb_r > 0 && pins.addr == program_addr_r) v = {~program_byte_r[7], tog_r, fl_r, 5'h00};
    else if (id_r) v = (pins.addr[1:0] == 2'h2) ? {7'h00, PROT[pins.addr[18:16]]}
      : pins.addr[0] ? DEV_ID : MAKER_ID;
    else if (eb_r > 0 && sect_r[pins.addr[18:16]]) v = {susp_r, tog_r, 6'h00};
    else v = rd(pins.addr);
  end
  // End of a read: remember the byte and flip the toggle bit while a program or unsuspended erase runs
  always @(posedge pins.oe_n) begin
    if (!pins.ce_n) begin
      last_r = v;
      if ((pb_r > 0 && !fl_r) || (eb_r > 0 && !susp_r)) tog_r = ~tog_r;
    end
  end
  // Released lines show the inverse of the last byte
  assign dq = (pins.oe_n || pins.ce_n) ? ~last_r : v;
endmodule : flash_dev_model
`default_nettype wire

// ==== tb/flash_host_bench.sv ====
// Self-checking bench for the flash host controller with a device model
`timescale 1ns/100ps
`default_nettype none
module flash_host_bench;
  import flash_host_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic fail_en = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  flash_pins_t pins;
  logic [7:0] dq;
  logic [31:0] rq, st;
  logic re;
  int miscompares = 0;
  int comparisons = 0;
  logic [26:0] wq [$];
  logic [18:0] ida [3] = '{19'h0_0001, 19'h7_0002, 19'h3_0002};
  logic [7:0] idd [3] = '{8'hc3, 8'h01, 8'h00};
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  flash_host dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .flash_pins(pins), .flash_dq_in(dq));
  flash_dev_model dev_u (.pins(pins), .fail_en(fail_en), .dq(dq));
  // Log of finished write cycles on the flash pins
  always @(posedge pins.we_n) if (presetn) wq.push_back({pins.addr, pins.dq_out});
  task automatic finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_wr(input logic [18:0] a, input logic [7:0] d, input logic ca);
    logic [26:0] w;
    w = (wq.size() > 0) ? wq.pop_front() : 'x;
    if (!ca) a = w[26:8];
    chk(32'(w), 32'({a, d}));
  endtask : chk_wr
  task automatic cmd(input logic [18:0] a, input logic [7:0] d);
    chk_wr(UNLOCK_ADDR_1, CMD_UNLOCK_1, 1'b1);
    chk_wr(UNLOCK_ADDR_2, CMD_UNLOCK_2, 1'b1);
    chk_wr(a, d, 1'b1);
  endtask : cmd
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    rq = rsp.prdata;
    re = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic run(input op_t o, input logic p, input logic [18:0] a, input logic [7:0] d);
    int n;
    apb(REG_ADDR, 1'b1, 32'(a));
    apb(REG_WDATA, 1'b1, 32'(d));
    wq.delete();
    apb(REG_CTRL, 1'b1, {23'h0, p, 4'h0, o});
    // A write while busy must be dropped
    apb(REG_WDATA, 1'b1, 32'(~d));
    n = 0;
    do begin
      apb(REG_STATUS, 1'b0, 32'h0000_0000);
      n++;
    end while (rq[0] !== 1'b0 && n < 4000);
    if (rq[0] !== 1'b0) begin
      miscompares++;
      finish_test();
    end
    st = rq;
    apb(REG_WDATA, 1'b0, 32'h0000_0000);
    chk(rq, 32'(d));
    apb(REG_RDATA, 1'b0, 32'h0000_0000);
  endtask : run
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(REG_STATUS, 1'b0, 32'h0000_0000);
    chk(rq, 32'h0000_0000);
    apb(8'h14, 1'b0, 32'h0000_0000);
    chk({31'h0, re}, 32'h0000_0001);
    // Sector erase, a second sector, then suspend
    run(OP_SECTOR_ERASE, 1'b0, 19'h3_0000, 8'h00);
    apb(REG_CTRL, 1'b0, 32'h0000_0000);
    chk(rq, 32'h0000_0004);
    apb(REG_ADDR, 1'b0, 32'h0000_0000);
    chk(rq, 32'h0003_0000);
    cmd(UNLOCK_ADDR_1, CMD_ERASE_SETUP);
    cmd(19'h3_0000, CMD_SECTOR_ERASE);
    run(OP_SECTOR_ADD, 1'b0, 19'h5_0000, 8'h00);
    chk_wr(19'h5_0000, CMD_SECTOR_ERASE, 1'b1);
    run(OP_SUSPEND, 1'b0, 19'h3_0000, 8'h00);
    chk_wr(19'h0_0000, CMD_SUSPEND, 1'b0);
    run(OP_READ, 1'b0, 19'h3_0004, 8'h00);
    chk(rq & 32'h0000_00bf, 32'h0000_0080);
    // Program in another sector while suspended
    run(OP_PROGRAM, 1'b1, 19'h1_2345, 8'h3c);
    cmd(UNLOCK_ADDR_1, CMD_PROGRAM);
    chk_wr(19'h1_2345, 8'h3c, 1'b1);
    chk(st, 32'h0000_0002);
    chk(rq, 32'h0000_003c);
    // Identification codes, then back out
    for (int i = 0; i < 3; i++) begin
      run(OP_IDENT, 1'b0, ida[i], 8'h00);
      cmd(UNLOCK_ADDR_1, CMD_IDENT);
      chk(rq, {24'h0, idd[i]});
    end
    run(OP_RESET, 1'b0, 19'h0_0000, 8'h00);
    chk_wr(19'h0_0000, CMD_RESET, 1'b0);
    // Resume and poll the erase to its end
    run(OP_RESUME, 1'b0, 19'h3_0000, 8'h00);
    chk_wr(19'h0_0000, CMD_RESUME, 1'b0);
    run(OP_POLL, 1'b1, 19'h3_0000, 8'h00);
    chk(st, 32'h0000_0002);
    chk(rq, 32'h0000_00ff);
    // Program into a protected sector
    run(OP_PROGRAM, 1'b1, 19'h7_0010, 8'h80);
    chk(st, 32'h0000_0002);
    chk(rq, 32'h0000_00ff);
    // Program that ends with the failure bit
    fail_en <= 1'b1;
    run(OP_PROGRAM, 1'b1, 19'h2_0001, 8'h5a);
    chk(st & 32'h0000_0005, 32'h0000_0004);
    run(OP_RESET, 1'b0, 19'h0_0000, 8'h00);
    chk_wr(19'h0_0000, CMD_RESET, 1'b0);
    fail_en <= 1'b0;
    // Whole-chip erase
    run(OP_CHIP_ERASE, 1'b1, 19'h0_0000, 8'h00);
    cmd(UNLOCK_ADDR_1, CMD_ERASE_SETUP);
    cmd(UNLOCK_ADDR_1, CMD_CHIP_ERASE);
    chk(st, 32'h0000_0002);
    finish_test();
  end
endmodule : flash_host_bench
`default_nettype wire
